// file: logic/supply_supervisor.sv
`timescale 1ns/1ps
module supply_supervisor
  import supply_pkg::*;
#(
  parameter int FAST_RISE = FAST_RISE_CYC,
  parameter int STAB_WAIT = STAB_WAIT_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   threshold_sel,
  input  wire logic                   supply_above_trip,
  input  wire logic                   supply_above_release,
  input  wire logic [LEVEL_COUNT-1:0] supply_above_level,
  input  wire logic                   external_above_ref,
  input  wire logic                   watchdog_reset_req,
  input  wire logic                   stop_mode,
  input  wire logic [15:0]            addr,
  input  wire logic                   wr_en,
  input  wire logic                   bit_wr,
  input  wire logic [2:0]             bit_sel,
  input  wire logic [7:0]             wr_data,
  input  wire logic                   rd_en,
  output logic      [7:0]             rd_data,
  output logic                        internal_reset,
  output logic                        undervoltage_irq,
  output logic      [3:0]             detection_level_select
);
  logic [LEVEL_COUNT-1:0] lvl_s;
  logic                   ext_s;
  logic                   trip_s;
  logic                   rel_s;
  logic                   por_active;
  logic                   enable_q, src_q, act_q;
  logic                   below_q;
  logic [7:0]             cause_q;
  logic                   lv_rst_q, wdt_rst_q;
  logic                   stop_seen_q;

  // Comparators are asynchronous to the system clock
  sync2 #(.W(LEVEL_COUNT + 3)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({supply_above_level, external_above_ref, supply_above_trip, supply_above_release}),
    .q   ({lvl_s, ext_s, trip_s, rel_s})
  );

  por_sequencer #(.FAST_RISE(FAST_RISE), .STAB_WAIT(STAB_WAIT)) u_por (
    .clk           (clk),
    .rst           (rst),
    .threshold_sel (threshold_sel),
    .above_trip    (trip_s),
    .above_release (rel_s),
    .por_active    (por_active)
  );

  // Selected comparison; stop mode does not gate it
  wire sel_above = src_q ? ext_s : lvl_s[detection_level_select];
  wire below     = enable_q & ~sel_above;
  wire lv_reset  = enable_q & act_q & ~sel_above;

  // Interrupt on each change of the gated flag in interrupt action only; disabling while below also fires
  wire irq_d = ~act_q & (below != below_q);

  // Register port decode
  wire ctrl_hit  = wr_en & (addr == CTRL_ADDR);
  wire level_hit = wr_en & (addr == LEVEL_ADDR) & ~bit_wr;
  wire cause_rd  = rd_en & (addr == CAUSE_ADDR);
  wire [7:0] bit_mask = 8'h01 << bit_sel;
  wire [7:0] cur_ctrl = {enable_q, 4'h0, src_q, act_q, below_q};
  wire [7:0] ctrl_new = bit_wr ? ((cur_ctrl & ~bit_mask) | (wr_data[0] ? bit_mask : 8'h00))
                               : wr_data;
  wire lvl_bit_hit = wr_en & bit_wr & (addr == LEVEL_ADDR) & (bit_sel < 3'h4);
  wire [3:0] lvl_mask = 4'h1 << bit_sel[1:0];
  // Read data selection; unknown addresses read zero
  wire [7:0] rd_sel   = (addr == CTRL_ADDR)  ? cur_ctrl :
                        (addr == LEVEL_ADDR) ? {4'h0, detection_level_select} :
                        (addr == CAUSE_ADDR) ? cause_q : REG_RESET;

  // Pending reset sources; a held detector reset keeps its state
  wire other_reset = por_active | wdt_rst_q;

  // Control fields: cleared by any reset other than the detector's
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_q <= 1'b0;
      src_q    <= 1'b0;
      act_q    <= 1'b0;
    end else if (other_reset) begin
      enable_q <= 1'b0;
      src_q    <= 1'b0;
      act_q    <= 1'b0;
    end else if (ctrl_hit) begin
      enable_q <= ctrl_new[EN_BIT];
      src_q    <= ctrl_new[SRC_BIT];
      act_q    <= ctrl_new[ACT_BIT];
    end
  end

  // Level select register survives the detector reset only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      detection_level_select <= LEVEL_RESET;
    end else if (other_reset) begin
      detection_level_select <= LEVEL_RESET;
    end else if (level_hit) begin
      detection_level_select <= wr_data[3:0];
    end else if (lvl_bit_hit) begin
      detection_level_select <= wr_data[0] ? (detection_level_select | lvl_mask)
                                           : (detection_level_select & ~lvl_mask);
    end
  end

  // Live flag and interrupt pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      below_q          <= 1'b0;
      undervoltage_irq <= 1'b0;
    end else begin
      below_q          <= below;
      undervoltage_irq <= irq_d;
    end
  end

  // Reset cause: power-on clears, other sources set own flag; set beats read-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_q <= REG_RESET;
    end else if (por_active) begin
      cause_q <= REG_RESET;
    end else begin
      if (cause_rd) cause_q <= REG_RESET;
      if (watchdog_reset_req) cause_q[WDT_CAUSE_BIT] <= 1'b1;
      if (lv_reset) cause_q[LV_CAUSE_BIT] <= 1'b1;
    end
  end

  // Reset outputs and read data are registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lv_rst_q       <= 1'b0;
      wdt_rst_q      <= 1'b0;
      internal_reset <= 1'b1;
      rd_data        <= REG_RESET;
      stop_seen_q    <= 1'b0;
    end else begin
      lv_rst_q       <= lv_reset;
      wdt_rst_q      <= watchdog_reset_req;
      internal_reset <= por_active | lv_reset | watchdog_reset_req;
      stop_seen_q    <= stop_mode;
      rd_data        <= rd_en ? rd_sel : REG_RESET;
    end
  end

  a_flag_when_off: assert property (@(posedge clk) disable iff (rst)
    !enable_q |=> !below_q) else $error("level flag set while disabled");
  a_lv_reset_out: assert property (@(posedge clk) disable iff (rst)
    (enable_q && act_q && !sel_above) |=> internal_reset) else $error("detector reset missing");
  a_lv_cause_set: assert property (@(posedge clk) disable iff (rst)
    (lv_reset && !por_active) |=> cause_q[LV_CAUSE_BIT]) else $error("cause bit not set");
  a_por_clears: assert property (@(posedge clk) disable iff (rst)
    por_active |=> cause_q == REG_RESET) else $error("power-on did not clear cause");
  a_irq_single: assert property (@(posedge clk) disable iff (rst)
    undervoltage_irq |=> !undervoltage_irq || $changed(below_q)) else $error("irq longer than pulse");
  a_irq_edges: assert property (@(posedge clk) disable iff (rst)
    ($changed(below_q) && !$past(act_q)) |-> undervoltage_irq) else $error("edge without irq");
  a_irq_in_reset: assert property (@(posedge clk) disable iff (rst)
    act_q |=> !undervoltage_irq) else $error("irq in reset action");
  a_ctrl_cleared: assert property (@(posedge clk) disable iff (rst)
    other_reset |=> !enable_q && !src_q && !act_q) else $error("control not cleared");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    $past(rd_en && addr == CTRL_ADDR) |-> rd_data[6:3] == 4'h0) else $error("reserved bits nonzero");

  // Level flag follows the selected comparison
  a_flag_below: assert property (@(posedge clk) disable iff (rst)
    (enable_q && !sel_above) |=> below_q)
    else $error("flag clear while below level");
  a_flag_above: assert property (@(posedge clk) disable iff (rst)
    (enable_q && sel_above) |=> !below_q)
    else $error("flag set while above level");
  a_src_external: assert property (@(posedge clk) disable iff (rst)
    (enable_q && src_q) |=> (below_q == !$past(ext_s)))
    else $error("external source not followed");
  a_src_supply: assert property (@(posedge clk) disable iff (rst)
    (enable_q && !src_q) |=> (below_q == !$past(lvl_s[detection_level_select])))
    else $error("selected supply level not followed");

  // A disabled detector stays silent
  a_off_no_reset: assert property (@(posedge clk) disable iff (rst)
    (!enable_q && !por_active && !watchdog_reset_req) |=> !internal_reset)
    else $error("reset while detector off");
  a_off_no_irq: assert property (@(posedge clk) disable iff (rst)
    (!enable_q && !below_q) |=> !undervoltage_irq)
    else $error("irq while detector off");

  // Reset output follows the detector only in reset action
  a_lv_release: assert property (@(posedge clk) disable iff (rst)
    (enable_q && act_q && sel_above && !por_active && !watchdog_reset_req) |=> !internal_reset)
    else $error("reset held above level");
  a_int_no_reset: assert property (@(posedge clk) disable iff (rst)
    (!act_q && !por_active && !watchdog_reset_req) |=> !internal_reset)
    else $error("reset in interrupt action");

  // Stop mode and power-on keep their reset path
  a_stop_runs: assert property (@(posedge clk) disable iff (rst)
    (stop_mode && lv_reset) |=> internal_reset)
    else $error("detector reset lost in stop mode");
  a_por_reset_out: assert property (@(posedge clk) disable iff (rst)
    por_active |=> internal_reset)
    else $error("power-on reset not driven");

  // Interrupt on both crossings and on disable, never when quiet
  a_irq_rise: assert property (@(posedge clk) disable iff (rst)
    (!act_q && enable_q && below_q && sel_above) |=> undervoltage_irq)
    else $error("no irq on return above level");
  a_irq_fall: assert property (@(posedge clk) disable iff (rst)
    (!act_q && enable_q && !below_q && !sel_above) |=> undervoltage_irq)
    else $error("no irq on drop below level");
  a_disable_irq: assert property (@(posedge clk) disable iff (rst)
    (!act_q && !enable_q && below_q) |=> undervoltage_irq)
    else $error("no irq on disable while below");
  a_irq_int_only: assert property (@(posedge clk) disable iff (rst)
    undervoltage_irq |-> !$past(act_q))
    else $error("irq from reset action");
  a_irq_no_change: assert property (@(posedge clk) disable iff (rst)
    (below == below_q) |=> !undervoltage_irq)
    else $error("irq without a change");

  // Cause flags: watchdog sets its own, detector keeps the other
  a_wdt_cause: assert property (@(posedge clk) disable iff (rst)
    (watchdog_reset_req && !por_active) |=> cause_q[WDT_CAUSE_BIT])
    else $error("watchdog cause not set");
  a_wdt_reset: assert property (@(posedge clk) disable iff (rst)
    watchdog_reset_req |=> internal_reset)
    else $error("watchdog reset not driven");
  a_lv_keeps_wdt: assert property (@(posedge clk) disable iff (rst)
    (lv_reset && !por_active && !cause_rd && cause_q[WDT_CAUSE_BIT]) |=> cause_q[WDT_CAUSE_BIT])
    else $error("detector reset lost watchdog cause");
  a_lv_cause_hold: assert property (@(posedge clk) disable iff (rst)
    (lv_rst_q && !$past(por_active)) |-> cause_q[LV_CAUSE_BIT])
    else $error("detector cause missing after reset");

  // Level select kept through the detector reset only
  a_level_kept: assert property (@(posedge clk) disable iff (rst)
    (!other_reset && !level_hit && !lvl_bit_hit) |=> $stable(detection_level_select))
    else $error("level select changed unasked");
  a_level_cleared: assert property (@(posedge clk) disable iff (rst)
    other_reset |=> (detection_level_select == LEVEL_RESET))
    else $error("level select not cleared");
  a_level_write: assert property (@(posedge clk) disable iff (rst)
    (level_hit && !other_reset) |=> (detection_level_select == $past(wr_data[3:0])))
    else $error("level byte write lost");
  a_level_bit: assert property (@(posedge clk) disable iff (rst)
    (lvl_bit_hit && !other_reset) |=> (detection_level_select[$past(bit_sel[1:0])] == $past(wr_data[0])))
    else $error("level bit write lost");

  // Control fields change only by a write or a non-detector reset
  a_ctrl_kept: assert property (@(posedge clk) disable iff (rst)
    (!other_reset && !ctrl_hit) |=> $stable({enable_q, src_q, act_q}))
    else $error("control changed unasked");
  a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
    (ctrl_hit && !other_reset) |=> ({enable_q, src_q, act_q} == $past({ctrl_new[EN_BIT], ctrl_new[SRC_BIT], ctrl_new[ACT_BIT]})))
    else $error("control write lost");

  // Read data reflects the register contents of the read cycle
  a_read_flag: assert property (@(posedge clk) disable iff (rst)
    $past(rd_en && addr == CTRL_ADDR) |-> (rd_data[FLAG_BIT] == $past(below_q)))
    else $error("flag read wrong");
  a_read_level: assert property (@(posedge clk) disable iff (rst)
    $past(rd_en && addr == LEVEL_ADDR) |-> (rd_data == {4'h0, $past(detection_level_select)}))
    else $error("level read wrong");
  a_read_cause: assert property (@(posedge clk) disable iff (rst)
    $past(rd_en && addr == CAUSE_ADDR) |-> (rd_data == $past(cause_q)))
    else $error("cause read wrong");
  c_lv_reset: cover property (@(posedge clk) lv_reset);
  c_irq_fall: cover property (@(posedge clk) undervoltage_irq && below_q);
  c_irq_rise: cover property (@(posedge clk) undervoltage_irq && !below_q);
  c_stop_det: cover property (@(posedge clk) stop_seen_q && lv_reset);
endmodule : supply_supervisor

// file: shared/supply_pkg.sv
package supply_pkg;
  // Register map of the documented processor port
  localparam logic [15:0] CTRL_ADDR    = 16'hFFBE;
  localparam logic [15:0] LEVEL_ADDR   = 16'hFFBF;
  localparam logic [15:0] CAUSE_ADDR   = 16'hFFAC;
  // Control register fields
  localparam int          EN_BIT       = 7;
  localparam int          SRC_BIT      = 2;
  localparam int          ACT_BIT      = 1;
  localparam int          FLAG_BIT     = 0;
  // Reset cause register fields
  localparam int          WDT_CAUSE_BIT = 4;
  localparam int          LV_CAUSE_BIT  = 0;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [3:0]  LEVEL_RESET  = 4'h0;
  localparam int          LEVEL_COUNT  = 16;
  // Stabilization wait after a fast rise to the higher release level
  localparam int          CLK_MHZ      = 100;
  localparam int          FAST_RISE_US = 1930;
  localparam int          STAB_WAIT_US = 5390;
  localparam int          FAST_RISE_CYC = FAST_RISE_US * CLK_MHZ;
  localparam int          STAB_WAIT_CYC = STAB_WAIT_US * CLK_MHZ;
  localparam int          CNT_W        = 20;
  // Reset source encoding, not used inside the block
  typedef enum logic [1:0] {SRC_NONE, SRC_POWER, SRC_WDT, SRC_LV} reset_src_e;
endpackage : supply_pkg

// file: logic/sync2.sv
`timescale 1ns/1ps
// Two-flop level synchroniser for comparator outputs
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sync2

// file: logic/por_sequencer.sv
`timescale 1ns/1ps
// Power-on clear: holds reset until the chosen release level is reached
module por_sequencer
  import supply_pkg::*;
#(
  parameter int FAST_RISE = FAST_RISE_CYC,
  parameter int STAB_WAIT = STAB_WAIT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic threshold_sel,
  input  wire logic above_trip,
  input  wire logic above_release,
  output logic      por_active
);
  typedef enum logic [1:0] {HOLD, RISING, STABILIZE, RUN} por_state_e;
  por_state_e      state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  wire  fast_rise = cnt_q < CNT_W'(FAST_RISE);

  // Release only on the level that the threshold option selects
  always_comb begin
    state_d = state_q;
    cnt_d   = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
    unique case (state_q)
      HOLD: if (above_trip) begin
        state_d = threshold_sel ? RISING : RUN;
        cnt_d   = '0;
      end
      RISING: if (above_release) begin
        state_d = fast_rise ? STABILIZE : RUN;
        cnt_d   = '0;
      end
      STABILIZE: if (cnt_q >= CNT_W'(STAB_WAIT - 1)) state_d = RUN;
      RUN: ;
    endcase
    if (!above_trip) begin
      state_d = HOLD;
      cnt_d   = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= HOLD;
      cnt_q      <= '0;
      por_active <= 1'b1;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      por_active <= (state_d != RUN);
    end
  end

  a_por_trip_reset: assert property (@(posedge clk) disable iff (rst)
    !above_trip |=> por_active) else $error("reset not held below trip level");
  a_por_low_mode: assert property (@(posedge clk) disable iff (rst)
    (state_q == HOLD && above_trip && !threshold_sel) |=> !por_active)
    else $error("low option did not release");
  a_por_high_mode: assert property (@(posedge clk) disable iff (rst)
    (threshold_sel && !above_release && state_q != RUN) |=> por_active)
    else $error("high option released early");
  c_por_stab: cover property (@(posedge clk) state_q == STABILIZE);
endmodule : por_sequencer

// file: sim/comparator_bank.sv
`timescale 1ns/1ps
// Analog comparators ahead of the supervisor; voltages given in millivolts
module comparator_bank (
  input  wire logic [15:0] supply_mv,
  input  wire logic [15:0] ext_mv,
  output logic             above_trip,
  output logic             above_release,
  output logic      [15:0] above_level,
  output logic             above_ref
);
  // Sixteen supply levels, highest first; index equals the level code
  localparam logic [15:0] LVL_MV [16] = '{16'h1090, 16'h0FFA, 16'h0F5A, 16'h0EC4, 16'h0E24, 16'h0D8E,
    16'h0CF8, 16'h0C58, 16'h0BC2, 16'h0B22, 16'h0A8C, 16'h09F6, 16'h0956, 16'h08C0, 16'h0820, 16'h078A};
  // Fixed trip, release and external reference levels; no hysteresis modelled
  assign above_trip    = supply_mv >= 16'h0636;
  assign above_release = supply_mv >= 16'h0A8C;
  assign above_ref     = ext_mv >= 16'h04BA;
  // Level bank compares all sixteen at once; the block picks one
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      above_level[i] = supply_mv >= LVL_MV[i];
    end
  end
endmodule : comparator_bank

// file: sim/test_supply_supervisor.sv
`timescale 1ns/1ps
// Power-up, detector and reset-source scenarios for the supply supervisor
module test_supply_supervisor;
  import supply_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, threshold_sel = 1'b0, watchdog_reset_req = 1'b0, stop_mode = 1'b0;
  logic        wr_en = 1'b0, bit_wr = 1'b0, rd_en = 1'b0, internal_reset, undervoltage_irq;
  logic        a_trip, a_rel, a_ref;
  logic [2:0]  bit_sel = 3'h0;
  logic [3:0]  level_sel;
  logic [7:0]  wr_data = 8'h00, rd_data;
  logic [15:0] addr = 16'h0000, supply_mv = 16'h0000, ext_mv = 16'h0000, a_lvl;
  int          bad_count = 0, compares = 0;
  // Short counts keep the stabilization wait visible in a brief run
  supply_supervisor #(.FAST_RISE(20), .STAB_WAIT(50)) dut (.clk(clk), .rst(rst), .threshold_sel(threshold_sel),
    .supply_above_trip(a_trip), .supply_above_release(a_rel), .supply_above_level(a_lvl),
    .external_above_ref(a_ref), .watchdog_reset_req(watchdog_reset_req), .stop_mode(stop_mode), .addr(addr),
    .wr_en(wr_en), .bit_wr(bit_wr), .bit_sel(bit_sel), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
    .internal_reset(internal_reset), .undervoltage_irq(undervoltage_irq), .detection_level_select(level_sel));
  comparator_bank cmp (.supply_mv(supply_mv), .ext_mv(ext_mv), .above_trip(a_trip), .above_release(a_rel),
    .above_level(a_lvl), .above_ref(a_ref));
  // 100 MHz clock
  always #5 clk = ~clk;
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Request held until the taking edge and dropped at that same edge
  task wr(input logic [15:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
    @(posedge clk) begin wr_en <= 1'b1; addr <= a; wr_data <= d; bit_wr <= b; bit_sel <= s; end
    @(posedge clk) wr_en <= 1'b0;
  endtask : wr
  // Read data is registered at the taking edge, so it is sampled just after it
  task rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk) begin rd_en <= 1'b1; addr <= a; end
    @(posedge clk) rd_en <= 1'b0;
    #1 check(rd_data, exp);
  endtask : rd
  task wait_rst(input logic v, input int n);
    for (int i = 0; i < n && internal_reset !== v; i++) @(posedge clk) #1;
    check({7'h00, internal_reset}, {7'h00, v});
  endtask : wait_rst
  // Pulse must come within n cycles and last exactly one
  task irq_in(input int n);
    for (int i = 0; i < n && undervoltage_irq !== 1'b1; i++) @(posedge clk) #1;
    check({7'h00, undervoltage_irq}, 8'h01);
    @(posedge clk) #1 check({7'h00, undervoltage_irq}, 8'h00);
  endtask : irq_in
  task t_power_low;
    @(posedge clk) rst <= 1'b0;
    repeat (10) @(posedge clk);
    #1 check({7'h00, internal_reset}, 8'h01);
    @(posedge clk) supply_mv <= 16'h0CE4;
    wait_rst(1'b0, 20);
    rd(CAUSE_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h00);
    $display("t_power_low done");
  endtask : t_power_low
  task t_ctrl_irq;
    wr(LEVEL_ADDR, 8'h0F, 1'b0, 3'h0);
    rd(LEVEL_ADDR, 8'h0F);
    check({4'h0, level_sel}, 8'h0F);
    // Flag and reserved bits written as ones must read back as zero
    wr(CTRL_ADDR, 8'hFB, 1'b0, 3'h0);
    rd(CTRL_ADDR, 8'h82);
    wr(CTRL_ADDR, 8'h80, 1'b0, 3'h0);
    @(posedge clk) supply_mv <= 16'h0708;
    irq_in(8);
    rd(CTRL_ADDR, 8'h81);
    wr(CTRL_ADDR, 8'h00, 1'b1, 3'h0);
    rd(CTRL_ADDR, 8'h81);
    @(posedge clk) supply_mv <= 16'h0CE4;
    irq_in(8);
    wr(CTRL_ADDR, 8'h01, 1'b1, 3'h2);
    repeat (4) @(posedge clk);
    rd(CTRL_ADDR, 8'h85);
    wr(CTRL_ADDR, 8'h00, 1'b1, 3'h7);
    irq_in(8);
    rd(CTRL_ADDR, 8'h04);
    $display("t_ctrl_irq done");
  endtask : t_ctrl_irq
  task t_lv_wdt;
    wr(CTRL_ADDR, 8'h82, 1'b0, 3'h0);
    @(posedge clk) begin stop_mode <= 1'b1; supply_mv <= 16'h0708; end
    wait_rst(1'b1, 10);
    @(posedge clk) supply_mv <= 16'h0CE4;
    wait_rst(1'b0, 10);
    @(posedge clk) stop_mode <= 1'b0;
    rd(CTRL_ADDR, 8'h82);
    rd(LEVEL_ADDR, 8'h0F);
    // Bit writes move the level to code 7; bit 6 is outside the field
    wr(LEVEL_ADDR, 8'h00, 1'b1, 3'h3);
    wr(LEVEL_ADDR, 8'h01, 1'b1, 3'h6);
    #1 check({4'h0, level_sel}, 8'h07);
    @(posedge clk) supply_mv <= 16'h0C1C;
    wait_rst(1'b1, 10);
    @(posedge clk) supply_mv <= 16'h0CE4;
    wait_rst(1'b0, 10);
    @(posedge clk) watchdog_reset_req <= 1'b1;
    @(posedge clk) watchdog_reset_req <= 1'b0;
    #1 check({7'h00, internal_reset}, 8'h01);
    wait_rst(1'b0, 50);
    rd(CAUSE_ADDR, 8'h11);
    rd(CAUSE_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h00);
    rd(LEVEL_ADDR, 8'h00);
    check({4'h0, level_sel}, 8'h00);
    $display("t_lv_wdt done");
  endtask : t_lv_wdt
  task t_power_high;
    @(posedge clk) begin rst <= 1'b1; threshold_sel <= 1'b1; supply_mv <= 16'h0000; end
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) supply_mv <= 16'h07D0;
    repeat (10) @(posedge clk);
    #1 check({7'h00, internal_reset}, 8'h01);
    @(posedge clk) supply_mv <= 16'h0CE4;
    repeat (30) @(posedge clk);
    #1 check({7'h00, internal_reset}, 8'h01);
    wait_rst(1'b0, 100);
    rd(CAUSE_ADDR, 8'h00);
    @(posedge clk) supply_mv <= 16'h0500;
    wait_rst(1'b1, 10);
    $display("t_power_high done");
  endtask : t_power_high
  task summarize;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge clk);
    t_power_low();
    t_ctrl_irq();
    t_lv_wdt();
    t_power_high();
    summarize();
  end
  // The tests take under two thousand cycles; this cuts a hang short
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule : test_supply_supervisor
